// File: logic/phy_link_monitor.sv
/*
 * Link monitor and reset control of a dual-speed PHY,
 * with APB registers.
 * Assumes same-clock receive events; async straps and fault pins.
 */
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "phy_link_consts.svh"
module phy_link_monitor import phy_link_pkg::*; #(
    parameter cnt_t JABBER_LIMIT = cnt_t'(`JABBER_LIMIT_CYC),
    parameter cnt_t JABBER_HOLD = cnt_t'(`JABBER_HOLD_CYC),
    parameter cnt_t LOCK_LOSS = cnt_t'(`LOCK_LOSS_CYC),
    parameter cnt_t POL_IDLE = cnt_t'(`POL_IDLE_CYC),
    parameter cnt_t LINK_LOSS = cnt_t'(`LINK_LOSS_CYC),
    parameter cnt_t NLP_PERIOD = cnt_t'(`NLP_PERIOD_CYC),
    parameter cnt_t INT_RESET = cnt_t'(`INT_RESET_CYC)
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Pins
    input wire logic power_save_input_in,
    input wire logic low_supply_in,
    input wire logic [4:0] multi_function_straps_in,
    input wire logic config_strap_zero_in,
    input wire logic config_strap_one_in,
    input wire logic duplex_strap_in,
    // Receive side events and symbols
    input wire rx_evt_t rx_evt_in,
    input wire logic symbol_good_in,
    input wire logic symbol_error_limit_in,
    input wire logic scrambler_locked_in,
    input wire sym_t rx_sym_in,
    // MAC transmit side
    input wire logic tx_en_in,
    input wire sym_t tx_sym_in,
    // Outputs
    output sym_t tx_sym_out,
    output sym_t rx_sym_out,
    output logic raw_symbol_mode_out,
    output logic tx_enable_out,
    output logic loopback_enable_out,
    output logic normal_link_pulse_out,
    output logic nrzi_enable_out,
    output logic crs_out,
    output logic col_out,
    output logic rx_er_out,
    output logic link_up_out,
    output logic autoneg_restart_out,
    output logic polarity_inverted_out,
    output logic internal_reset_out
);
    localparam logic [7:0] HB_CYC = 8'(`HEARTBEAT_CYC);
    localparam logic [4:0] SOFT_CYC = 5'(`SOFT_RESET_CYC);

    logic [9:0] pin_s1, pin_s2;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            pin_s1 <= 10'h000;
            pin_s2 <= 10'h000;
        end else begin
            pin_s1 <= {power_save_input_in, low_supply_in, multi_function_straps_in,
                       config_strap_zero_in, config_strap_one_in, duplex_strap_in};
            pin_s2 <= pin_s1;
        end
    end
    logic power_save, low_supply, strap_autoneg, strap_config_strap_zero, strap_config_strap_one, strap_fde;
    assign power_save = pin_s2[9];
    assign low_supply = pin_s2[8];
    assign strap_autoneg = pin_s2[3];
    assign strap_config_strap_zero = pin_s2[2];
    assign strap_config_strap_one = pin_s2[1];
    assign strap_fde = pin_s2[0];

    cnt_t int_cnt;
    logic in_reset, soft_busy, reload;
    logic [4:0] soft_cnt;
    logic soft_req;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            int_cnt <= '0;
            in_reset <= 1'b1;
        end else if (in_reset) begin
            int_cnt <= int_cnt + 25'd1;
            if (int_cnt == INT_RESET - 25'd1) in_reset <= 1'b0;
        end
    end
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            soft_cnt <= '0;
            soft_busy <= 1'b0;
        end else if (soft_req) begin
            soft_cnt <= '0;
            soft_busy <= 1'b1;
        end else if (soft_busy) begin
            soft_cnt <= soft_cnt + 5'd1;
            if (soft_cnt == SOFT_CYC - 5'd1) soft_busy <= 1'b0;
        end
    end
    assign reload = (in_reset && int_cnt == INT_RESET - 25'd1) || (soft_busy && soft_cnt == SOFT_CYC - 5'd1);
    logic func_rst;
    assign func_rst = in_reset || soft_busy || power_save;
    assign internal_reset_out = in_reset;

    logic autoneg_en, speed_100, full_duplex, fiber, enh_link, bypass;
    logic heartbeat_en, jabber_off, linktest_off;
    logic apb_wr, apb_rd, hit;
    logic [11:0] word_addr;
    assign word_addr = paddr_in >> 2;
    assign hit = word_addr == 12'(`REG_CTRL_IDX) || word_addr == 12'(`REG_CFG_A_IDX)
              || word_addr == 12'(`REG_CFG_B_IDX) || word_addr == 12'(`REG_STATUS_IDX);
    assign apb_wr = psel_in && penable_in && pwrite_in && hit && !in_reset;
    assign soft_req = apb_wr && word_addr == 12'(`REG_CTRL_IDX) && pwdata_in[`CTRL_SOFT_RESET];
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && (!hit || in_reset);
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            autoneg_en <= 1'b0;
            speed_100 <= 1'b0;
            full_duplex <= 1'b0;
            fiber <= 1'b0;
        end else if (reload) begin
            autoneg_en <= strap_autoneg;
            speed_100 <= strap_config_strap_zero;
            full_duplex <= strap_fde;
            fiber <= 1'b0;
        end else if (apb_wr && word_addr == 12'(`REG_CTRL_IDX) && !soft_busy) begin
            autoneg_en <= pwdata_in[`CTRL_AUTONEG];
            speed_100 <= pwdata_in[`CTRL_SPEED_100] || pwdata_in[`CTRL_FIBER];
            full_duplex <= pwdata_in[`CTRL_FULL_DUPLEX];
            fiber <= pwdata_in[`CTRL_FIBER];
        end
    end
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || reload) begin
            enh_link <= 1'(`CFG_A_RESET >> `CFG_A_ENH_LINK);
            bypass <= 1'(`CFG_A_RESET >> `CFG_A_BYPASS);
        end else if (apb_wr && word_addr == 12'(`REG_CFG_A_IDX) && !soft_busy) begin
            enh_link <= pwdata_in[`CFG_A_ENH_LINK];
            bypass <= pwdata_in[`CFG_A_BYPASS];
        end
    end
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || reload) begin
            heartbeat_en <= 1'(`CFG_B_RESET >> `CFG_B_HEARTBEAT);
            jabber_off <= 1'(`CFG_B_RESET >> `CFG_B_JABBER_OFF);
            linktest_off <= 1'(`CFG_B_RESET >> `CFG_B_LINKTEST_OFF);
        end else if (apb_wr && word_addr == 12'(`REG_CFG_B_IDX) && !soft_busy) begin
            heartbeat_en <= pwdata_in[`CFG_B_HEARTBEAT];
            jabber_off <= pwdata_in[`CFG_B_JABBER_OFF];
            linktest_off <= pwdata_in[`CFG_B_LINKTEST_OFF];
        end
    end

    jab_state_t jab_state;
    cnt_t jab_cnt;
    logic tx_en_d;
    logic [7:0] hb_cnt;
    logic ten_mode;
    assign ten_mode = !speed_100 && !fiber;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || func_rst || jabber_off || !ten_mode) begin
            jab_state <= JAB_CLEAR;
            jab_cnt <= '0;
        end else begin
            case (jab_state)
                JAB_CLEAR: begin
                    jab_cnt <= tx_en_in ? jab_cnt + 25'd1 : '0;
                    if (tx_en_in && jab_cnt == JABBER_LIMIT - 25'd1) begin
                        jab_state <= JAB_ACTIVE;
                        jab_cnt <= '0;
                    end
                end
                JAB_ACTIVE: begin
                    jab_cnt <= jab_cnt + 25'd1;
                    if (jab_cnt == JABBER_HOLD - 25'd1) begin
                        jab_state <= JAB_CLEAR;
                        jab_cnt <= '0;
                    end
                end
                default: jab_state <= JAB_CLEAR;
            endcase
        end
    end
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || func_rst) begin
            tx_en_d <= 1'b0;
            hb_cnt <= '0;
        end else begin
            tx_en_d <= tx_en_in;
            if (tx_en_d && !tx_en_in && heartbeat_en && ten_mode) hb_cnt <= HB_CYC;
            else if (hb_cnt != 8'd0) hb_cnt <= hb_cnt - 8'd1;
        end
    end

    logic link100, lock_lost_long;
    cnt_t lock_cnt;
    logic enh_active;
    assign enh_active = enh_link && !bypass;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || func_rst || scrambler_locked_in) lock_cnt <= '0;
        else if (lock_cnt != LOCK_LOSS) lock_cnt <= lock_cnt + 25'd1;
    end
    assign lock_lost_long = enh_active && lock_cnt == LOCK_LOSS;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || func_rst || !speed_100) link100 <= 1'b0;
        else if (link100 && (lock_lost_long || (!enh_active && symbol_error_limit_in))) link100 <= 1'b0;
        else if (!link100 && symbol_good_in && !lock_lost_long) link100 <= 1'b1;
    end

    lt_state_t lt_state;
    logic [2:0] nlp_cnt;
    cnt_t silence_cnt;
    logic lt_disabled, link10;
    assign lt_disabled = linktest_off || (!strap_autoneg && strap_config_strap_one);
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || func_rst || !ten_mode) begin
            lt_state <= LT_WAIT;
            nlp_cnt <= '0;
            silence_cnt <= '0;
        end else begin
            silence_cnt <= (rx_evt_in.link_pulse || rx_evt_in.data) ? '0 : silence_cnt + 25'd1;
            case (lt_state)
                LT_WAIT: begin
                    if (lt_disabled) lt_state <= LT_OFF;
                    else if (rx_evt_in.link_pulse) begin
                        nlp_cnt <= nlp_cnt + 3'd1;
                        if (nlp_cnt == 3'(`NLP_TO_LINK - 1)) lt_state <= LT_UP;
                    end else if (silence_cnt == LINK_LOSS) nlp_cnt <= '0;
                end
                LT_UP: begin
                    if (lt_disabled) lt_state <= LT_OFF;
                    else if (silence_cnt == LINK_LOSS) begin
                        lt_state <= LT_WAIT;
                        nlp_cnt <= '0;
                    end
                end
                LT_OFF: if (!lt_disabled) lt_state <= LT_WAIT;
                default: lt_state <= LT_WAIT;
            endcase
        end
    end
    assign link10 = lt_state != LT_WAIT;

    logic link_now, link_q;
    assign link_now = speed_100 ? link100 : link10;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || func_rst) begin
            link_q <= 1'b0;
            autoneg_restart_out <= 1'b0;
        end else begin
            link_q <= link_now;
            autoneg_restart_out <= link_q && !link_now && autoneg_en;
        end
    end
    assign link_up_out = link_q;

    cnt_t nlp_timer;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || func_rst || !ten_mode) begin
            nlp_timer <= '0;
            normal_link_pulse_out <= 1'b0;
        end else begin
            nlp_timer <= (nlp_timer == NLP_PERIOD - 25'd1) ? '0 : nlp_timer + 25'd1;
            normal_link_pulse_out <= nlp_timer == NLP_PERIOD - 25'd1 && !low_supply;
        end
    end

    logic rx_crs;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || func_rst) begin
            rx_crs <= 1'b0;
            rx_er_out <= 1'b0;
        end else if (speed_100) begin
            rx_er_out <= rx_crs && rx_evt_in.idle && !rx_evt_in.tr;
            if (rx_evt_in.tr || rx_evt_in.idle) rx_crs <= 1'b0;
            else if (rx_evt_in.jk) rx_crs <= 1'b1;
        end else begin
            rx_er_out <= 1'b0;
            if (rx_evt_in.eof) rx_crs <= 1'b0;
            else if (rx_evt_in.preamble) rx_crs <= 1'b1;
        end
    end
    assign crs_out = rx_crs || (!full_duplex && tx_en_in && !func_rst);
    assign col_out = (jab_state == JAB_ACTIVE) || hb_cnt != 8'd0;

    logic [3:0] pol_pulses;
    logic [2:0] pol_markers;
    cnt_t pol_silence;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || func_rst) begin
            pol_pulses <= '0;
            pol_markers <= '0;
            pol_silence <= '0;
            polarity_inverted_out <= 1'b0;
        end else begin
            pol_silence <= (rx_evt_in.link_pulse || rx_evt_in.link_pulse_inverted || rx_evt_in.data)
                ? '0 : pol_silence + 25'd1;
            if (rx_evt_in.link_pulse_inverted) pol_pulses <= pol_pulses + 4'd1;
            else if (rx_evt_in.link_pulse) pol_pulses <= '0;
            if (rx_evt_in.eof_inverted) pol_markers <= pol_markers + 3'd1;
            else if (rx_evt_in.eof) pol_markers <= '0;
            if (pol_silence == POL_IDLE - 25'd1) begin
                polarity_inverted_out <= 1'b0;
                pol_pulses <= '0;
                pol_markers <= '0;
            end else if ((rx_evt_in.link_pulse_inverted && pol_pulses == 4'(`POL_PULSES - 1))
                || (rx_evt_in.eof_inverted && pol_markers == 3'(`POL_MARKERS - 1))) begin
                polarity_inverted_out <= 1'b1;
                pol_pulses <= '0;
                pol_markers <= '0;
            end
        end
    end

    // x^11 + x^9 + 1, five steps per symbol
    function automatic logic [15:0] lfsr5(input logic [10:0] s);
        logic [10:0] st;
        logic [4:0] key;
        st = s;
        key = '0;
        for (int i = 0; i < 5; i++) begin
            key[i] = st[10] ^ st[8];
            st = {st[9:0], key[i]};
        end
        return {st, key};
    endfunction
    logic [10:0] scr, dscr;
    logic [15:0] scr_nx, dscr_nx;
    assign scr_nx = lfsr5(scr);
    assign dscr_nx = lfsr5(dscr);
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || func_rst) scr <= `SCR_SEED;
        else scr <= scr_nx[15:5];
    end
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || func_rst) dscr <= `SCR_SEED;
        else if (rx_evt_in.idle) dscr <= {dscr[5:0], ~rx_sym_in};
        else dscr <= dscr_nx[15:5];
    end
    logic tx_allowed;
    assign tx_allowed = !func_rst && !low_supply && jab_state != JAB_ACTIVE
                     && (speed_100 || link10);
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || func_rst) begin
            tx_sym_out <= '0;
            rx_sym_out <= '0;
        end else begin
            tx_sym_out <= !tx_allowed ? '0 : (bypass || fiber || !speed_100) ? tx_sym_in
                          : tx_sym_in ^ scr_nx[4:0];
            rx_sym_out <= (bypass || fiber || !speed_100) ? rx_sym_in : rx_sym_in ^ dscr_nx[4:0];
        end
    end
    assign raw_symbol_mode_out = bypass;
    assign tx_enable_out = tx_allowed;
    assign loopback_enable_out = !func_rst && jab_state != JAB_ACTIVE;
    assign nrzi_enable_out = fiber && speed_100 && !func_rst;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (word_addr == 12'(`REG_CTRL_IDX)) begin
            rd_mux[`CTRL_SOFT_RESET] = soft_busy;
            rd_mux[`CTRL_SPEED_100] = speed_100;
            rd_mux[`CTRL_AUTONEG] = autoneg_en;
            rd_mux[`CTRL_FULL_DUPLEX] = full_duplex;
            rd_mux[`CTRL_FIBER] = fiber;
        end else if (word_addr == 12'(`REG_CFG_A_IDX)) begin
            rd_mux[`CFG_A_ENH_LINK] = enh_link;
            rd_mux[`CFG_A_BYPASS] = bypass;
        end else if (word_addr == 12'(`REG_CFG_B_IDX)) begin
            rd_mux[`CFG_B_HEARTBEAT] = heartbeat_en;
            rd_mux[`CFG_B_JABBER_OFF] = jabber_off;
            rd_mux[`CFG_B_LINKTEST_OFF] = linktest_off;
        end else if (word_addr == 12'(`REG_STATUS_IDX)) begin
            rd_mux[`ST_LINK_UP] = link_q;
            rd_mux[`ST_POL_INV] = polarity_inverted_out;
            rd_mux[`ST_LOW_SUPPLY] = low_supply;
            rd_mux[`ST_JABBER] = jab_state == JAB_ACTIVE;
            rd_mux[`ST_SPEED_100] = speed_100;
        end
    end
    assign apb_rd = psel_in && !penable_in && !pwrite_in;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) prdata_out <= 32'h0000_0000;
        else if (apb_rd) prdata_out <= in_reset ? 32'h0000_0000 : rd_mux;
    end
endmodule
`default_nettype wire

// File: logic/phy_link_consts.svh
/*
 * Register fields and timing figures of the link monitor.
 * Assumes a 40 MHz clock; times become cycle counts here.
 */
//
// Overview of operation
// - Heartbeat collision pulse after each 10M packet
// - Jabber stops transmit, loopback, raises collision
// - Jabber state ends by itself after hold
// - Jabber disable bit turns protection off
// - Default criterion: link follows symbol error rate
// - 100M link loss restarts negotiation if enabled
// - Enhanced criterion: scrambler lock loss drops link
// - 10M sends link pulses; pulses enable transmit
// - Missing pulses fail link, restart negotiation
// - Link test disabled by bit or straps
// - 100M carrier sense from J/K to T/R
// - Idle without T/R: drop, one-cycle error
// - 10M carrier sense from preamble to end-of-frame
// - Data-free 11-bit scrambler, descrambler acquires on idle
// - Scrambler bypass also bypasses encoder, raw symbols
// - Eight inverted pulses or four markers invert
// - Long silence returns polarity to normal
// - Fiber uses NRZI at 100M, no signal-detect
// - Low supply disables transmit, sets status bit
// - Power save stops all but register access
// - Soft reset bit reloads straps, self-clears
// - Internal reset holds registers off after release
// - Half duplex carrier includes transmit activity
`ifndef PHY_LINK_CONSTS_SVH
`define PHY_LINK_CONSTS_SVH

`define CLK_MHZ 40
`define BIT_TIME_NS 100
`define BIT_TIME_CYC ((`BIT_TIME_NS * `CLK_MHZ + 999) / 1000)
`define HEARTBEAT_BT 10
`define HEARTBEAT_CYC (`HEARTBEAT_BT * `BIT_TIME_CYC)
`define JABBER_LIMIT_MS 20
`define JABBER_LIMIT_CYC (`JABBER_LIMIT_MS * 1000 * `CLK_MHZ)
`define JABBER_HOLD_MS 500
`define JABBER_HOLD_CYC (`JABBER_HOLD_MS * 1000 * `CLK_MHZ)
`define LOCK_LOSS_US 1500
`define LOCK_LOSS_CYC (`LOCK_LOSS_US * `CLK_MHZ)
`define POL_IDLE_MS 112
`define POL_IDLE_CYC (`POL_IDLE_MS * 1000 * `CLK_MHZ)
`define LINK_LOSS_MS 100
`define LINK_LOSS_CYC (`LINK_LOSS_MS * 1000 * `CLK_MHZ)
`define NLP_PERIOD_MS 16
`define NLP_PERIOD_CYC (`NLP_PERIOD_MS * 1000 * `CLK_MHZ)
`define INT_RESET_US 300
`define INT_RESET_CYC (`INT_RESET_US * `CLK_MHZ)
`define SOFT_RESET_CYC 16
`define NLP_TO_LINK 4
`define POL_PULSES 8
`define POL_MARKERS 4

`define REG_CTRL_IDX 0
`define REG_CFG_A_IDX 17
`define REG_CFG_B_IDX 19
`define REG_STATUS_IDX 20
`define CTRL_SOFT_RESET 15
`define CTRL_SPEED_100 13
`define CTRL_AUTONEG 12
`define CTRL_FULL_DUPLEX 8
`define CTRL_FIBER 7
`define CFG_A_ENH_LINK 2
`define CFG_A_BYPASS 0
`define CFG_B_HEARTBEAT 10
`define CFG_B_JABBER_OFF 9
`define CFG_B_LINKTEST_OFF 8
`define ST_LINK_UP 4
`define ST_POL_INV 3
`define ST_LOW_SUPPLY 2
`define ST_JABBER 1
`define ST_SPEED_100 0
`define CFG_A_RESET 32'h0000_0000
`define CFG_B_RESET 32'h0000_0000
`define SCR_SEED 11'h7ff

`endif

// File: logic/phy_link_pkg.sv
/*
 * Types shared by the PHY link monitor.
 * Assumes the constants header is compiled alongside.
 */
package phy_link_pkg;
    typedef logic [24:0] cnt_t;
    typedef logic [4:0] sym_t;
    typedef struct packed {
        logic jk;
        logic tr;
        logic idle;
        logic preamble;
        logic eof;
        logic eof_inverted;
        logic link_pulse;
        logic link_pulse_inverted;
        logic data;
    } rx_evt_t;
    typedef enum logic {JAB_CLEAR, JAB_ACTIVE} jab_state_t;
    typedef enum logic [1:0] {LT_WAIT, LT_UP, LT_OFF} lt_state_t;
endpackage

// File: sim/phy_link_monitor_assertions.sv
/* Port-level checker of the link monitor.
   Assumes the block's clock and synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module phy_link_monitor_assertions (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Watched ports
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic power_save_input_in,
    input wire logic low_supply_in,
    input wire logic tx_en_in,
    input wire logic pslverr_out,
    input wire logic tx_enable_out,
    input wire logic crs_out,
    input wire logic col_out,
    input wire logic rx_er_out,
    input wire logic normal_link_pulse_out,
    input wire logic autoneg_restart_out,
    input wire logic internal_reset_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    AST_RXER_ONE: assert property (rx_er_out |=> !rx_er_out) else $error("rx error too long");
    AST_RXER_CRS: assert property (rx_er_out && !tx_en_in |-> !crs_out) else $error("carrier with rx error");
    AST_RESTART_ONE: assert property (autoneg_restart_out |=> !autoneg_restart_out) else $error("restart long");
    // Four cycles cover the two-stage pin synchroniser
    AST_LOW_TX: assert property (low_supply_in [*4] |-> !tx_enable_out) else $error("tx on low supply");
    AST_SAVE_OFF: assert property (power_save_input_in [*5] |-> !(tx_enable_out || crs_out || col_out))
        else $error("active in power save");
    AST_IRST_ON: assert property (disable iff (1'b0) !rst_n_in |=> internal_reset_out)
        else $error("no internal reset");
    AST_IRST_ERR: assert property (internal_reset_out && psel_in && penable_in |-> pslverr_out)
        else $error("register open in reset");
    AST_NLP_ONE: assert property (normal_link_pulse_out |=> !normal_link_pulse_out [*2])
        else $error("link pulse too long");
endmodule
bind phy_link_monitor phy_link_monitor_assertions u_chk (.*);
`default_nettype wire

// File: sim/mac_model.sv
/* MAC transmit side: sends one frame of a given length on request.
   Assumes the system clock and reset of the monitor. */
`timescale 1ns/1ps
`default_nettype none
module mac_model import phy_link_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic [7:0] len_in,
    output logic tx_en_out,
    output sym_t tx_sym_out
);
    logic [7:0] left;
    // Symbols run on outside frames so stale data is never mistaken for idle
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            left <= 8'h00;
            tx_sym_out <= 5'h00;
        end else begin
            tx_sym_out <= tx_sym_out + 5'h01;
            left <= start_in ? len_in : left - 8'(left != 8'h00);
        end
    end
    assign tx_en_out = (left != 8'h00);
endmodule
`default_nettype wire

// File: sim/phy_link_monitor_bench.sv
/* Self-checking bench of the link monitor, APB master and MAC model.
   Assumes package, checker and MAC model compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "phy_link_consts.svh"
module phy_link_monitor_bench import phy_link_pkg::*; ();
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pwr = 1'b0, lowv = 1'b0, mstart = 1'b0, serr;
    logic cz = 1'b0, co = 1'b0, fde = 1'b0, sgd = 1'b1, serl = 1'b0, slk = 1'b1;
    logic [4:0] mfs = 5'h00;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, rdata, prdata;
    logic [7:0] mlen = 8'h00;
    rx_evt_t evt = '0;
    int num_errors = 0, cmp_count = 0, n;
    logic pready, pslverr, tx_en, txen_o, crs, col, rx_er, link_up, restart, pol, irst;
    sym_t txs;
    always #12.5 clk_sys_in = ~clk_sys_in;
    mac_model u_mac (.clk_in(clk_sys_in), .rst_n_in(rst_n_in), .start_in(mstart), .len_in(mlen),
        .tx_en_out(tx_en), .tx_sym_out(txs));
    phy_link_monitor #(.JABBER_LIMIT(50), .JABBER_HOLD(100), .POL_IDLE(200), .LINK_LOSS(60),
        .NLP_PERIOD(30)) u_dut (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .power_save_input_in(pwr), .low_supply_in(lowv),
        .multi_function_straps_in(mfs), .config_strap_zero_in(cz), .config_strap_one_in(co),
        .duplex_strap_in(fde), .rx_evt_in(evt), .symbol_good_in(sgd), .symbol_error_limit_in(serl),
        .scrambler_locked_in(slk), .rx_sym_in(txs), .tx_en_in(tx_en), .tx_sym_in(txs),
        .tx_sym_out(), .rx_sym_out(), .raw_symbol_mode_out(), .tx_enable_out(txen_o),
        .loopback_enable_out(), .normal_link_pulse_out(), .nrzi_enable_out(), .crs_out(crs),
        .col_out(col), .rx_er_out(rx_er), .link_up_out(link_up), .autoneg_restart_out(restart),
        .polarity_inverted_out(pol), .internal_reset_out(irst));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task wt(input int k);
        repeat (k) @(negedge clk_sys_in);
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge clk_sys_in);
        penable <= 1'b1;
        @(posedge clk_sys_in);
        while (pready !== 1'b1) @(posedge clk_sys_in);
        rdata = prdata;
        serr = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    // Event bit index, jk on top
    task ev(input int k);
        @(posedge clk_sys_in);
        evt <= rx_evt_t'(9'h001 << k);
        @(posedge clk_sys_in);
        evt <= '0;
    endtask
    task frame(input logic [7:0] len);
        @(posedge clk_sys_in);
        {mstart, mlen} <= {1'b1, len};
        @(posedge clk_sys_in);
        mstart <= 1'b0;
    endtask
    task t_reset();
        repeat (16) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        wt(1);
        chk(irst, 1);
        rd(12'h050);
        chk(serr, 1);
        n = 0;
        while (irst === 1'b1 && n < 20000) begin
            wt(1);
            n++;
        end
        chk(n inside {[`INT_RESET_CYC - 10:`INT_RESET_CYC]}, 1);
        rd(12'h044);
        chk(rdata, 32'h0000_0000);
        rd(12'h04C);
        chk(rdata, 32'h0000_0000);
        rd(12'h008);
        chk(serr, 1);
        mfs <= 5'h01;
        apb(1'b1, 12'h000, 32'h0000_8000);
        rd(12'h000);
        chk(rdata[15], 1);
        wt(30);
        rd(12'h000);
        chk(rdata, 32'h0000_1000);
        $display("test reset done");
    endtask
    task t_crs100();
        apb(1'b1, 12'h000, 32'h0000_2000);
        ev(8);
        wt(1);
        chk(crs, 1);
        ev(7);
        wt(1);
        chk(crs, 0);
        ev(8);
        ev(6);
        n = 0;
        repeat (6) begin
            wt(1);
            n += (rx_er === 1'b1);
        end
        chk(n, 1);
        chk(crs, 0);
        $display("test carrier done");
    endtask
    task t_tx10();
        apb(1'b1, 12'h000, 32'h0000_0000);
        apb(1'b1, 12'h04C, 32'h0000_0500);
        frame(8'h0A);
        wt(2);
        chk(crs, 1);
        n = 0;
        repeat (120) begin
            wt(1);
            n += (col === 1'b1);
        end
        chk(n inside {[20:60]}, 1);
        apb(1'b1, 12'h04C, 32'h0000_0100);
        frame(8'h50);
        wt(70);
        chk(col, 1);
        chk(txen_o, 0);
        wt(140);
        chk(col, 0);
        apb(1'b1, 12'h04C, 32'h0000_0300);
        frame(8'h50);
        wt(70);
        chk(col, 0);
        chk(txen_o, 1);
        @(posedge clk_sys_in);
        lowv <= 1'b1;
        wt(6);
        chk(txen_o, 0);
        rd(12'h050);
        chk(rdata[2], 1);
        lowv <= 1'b0;
        wt(6);
        chk(txen_o, 1);
        @(posedge clk_sys_in);
        pwr <= 1'b1;
        wt(8);
        chk(txen_o, 0);
        rd(12'h04C);
        chk(rdata, 32'h0000_0300);
        pwr <= 1'b0;
        wt(8);
        $display("test transmit done");
    endtask
    task t_pol();
        ev(5);
        wt(1);
        chk(crs, 1);
        ev(4);
        wt(1);
        chk(crs, 0);
        repeat (7) ev(1);
        wt(2);
        chk(pol, 0);
        ev(1);
        wt(2);
        chk(pol, 1);
        wt(240);
        chk(pol, 0);
        $display("test polarity done");
    endtask
    task t_link();
        apb(1'b1, 12'h000, 32'h0000_1000);
        apb(1'b1, 12'h04C, 32'h0000_0000);
        repeat (3) ev(2);
        wt(2);
        chk(link_up, 0);
        ev(2);
        wt(2);
        chk(link_up, 1);
        n = 0;
        repeat (120) begin
            wt(1);
            n += (restart === 1'b1);
        end
        chk(link_up, 0);
        chk(n > 0, 1);
        $display("test link done");
    endtask
    task print_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        t_reset();
        t_crs100();
        t_tx10();
        t_pol();
        t_link();
        print_verdict();
    end
    // Run is near 13000 cycles; wide margin
    initial begin
        #1_000_000;
        num_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
